// >>> sync_serial_port.sv
// synchronous serial port: apb registers, fifos and slave-clocked shifter
// Functional notes
// R1: serial operation runs only while port_enable_bit is 1; it resets to 0.
// R2: software clears port_enable_bit before rewriting any control register.
// R3: loopback_select 1 feeds transmit shifter output into the receive shifter.
// R4: loopback_select 0, the reset value, receives from the external serial input.
// R5: data window at 0x008, 16-bit data, shared for transmit and receive.
// R6: reading the data window returns the receive head and consumes it.
// R7: each received value is pushed at the receive write pointer; the code drops a value completed while the receive fifo is full.
// R8: writing the data window pushes into the transmit fifo.
// R9: transmit logic pops one value at a time into the shifter.
// R10: loaded values shift out on serial_output_pin at the link bit rate.
// R11: short frames take low-order transmit bits; upper bits are ignored.
// R12: short received frames are stored right-justified.
// R13: command format sends 8 transmit bits, ignoring the upper byte.
// R14: command format receive width follows the programmed frame size.
// R15: clearing port_enable_bit keeps both fifos and their pointers.
// R16: software may preload transmit data while disabled, then enable.
// R17: read-only status register at 0x00C shows fifo fill and busy.
// R18: status bit 4 is 1 while a frame runs or transmit data waits.
// R19: status tracks fifo occupancy every cycle; reset shows tx notfull and empty.
// R20: writes into a full tx fifo, reads from empty rx, move no pointers.
`timescale 1ns/1ps
module sync_serial_port #(
	parameter int FIFO_DEPTH_P = serial_port_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [serial_port_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic sclk_i,
	input wire logic frame_n_i,
	input wire logic serial_input_i,
	output logic serial_output_pin_o,
	output logic serial_output_oe_n_o
);
	import serial_port_pkg::*;

	initial begin
		if (FIFO_DEPTH_P < 2)
			$error("sync_serial_port fifo depth must be at least 2");
		if ((FIFO_DEPTH_P & (FIFO_DEPTH_P - 1)) != 0)
			$error("sync_serial_port fifo depth must be a power of two");
		if (DATA_W != 16)
			$error("sync_serial_port data window must be sixteen bits wide");
		if (int'(CMD_TX_BITS) + DATA_W > 31)
			$error("sync_serial_port bit counter too narrow for command frames");
	end

	// ---------------- apb decode ----------------
	wire setup_phase = psel_i & ~penable_i;
	wire access_phase = psel_i & penable_i;
	wire hit_cfg = paddr_i == FRAME_CFG_OFFSET;
	wire hit_ctl = paddr_i == CONTROL_ONE_OFFSET;
	wire hit_data = paddr_i == DATA_WINDOW_OFFSET;
	wire hit_stat = paddr_i == FIFO_STATUS_OFFSET;
	wire mapped = hit_cfg | hit_ctl | hit_data | hit_stat;
	// status is read-only, so a write there is refused like an unmapped access
	wire bad_access = ~mapped | (hit_stat & pwrite_i); // [R17]
	wire wr_cfg = access_phase & pwrite_i & hit_cfg;
	wire wr_ctl = access_phase & pwrite_i & hit_ctl;
	wire wr_data = access_phase & pwrite_i & hit_data; // [R5] [R8]
	wire rd_data = access_phase & ~pwrite_i & hit_data; // [R5] [R6]

	logic [3:0] size_m1_reg;
	logic cmd_format_reg;
	logic enable_reg;
	logic loopback_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;

	// ---------------- fifos ----------------
	logic [DATA_W-1:0] tx_head;
	logic [DATA_W-1:0] rx_head;
	logic tx_full;
	logic tx_empty;
	logic rx_full;
	logic rx_empty;
	logic tx_pop;
	logic rx_push;
	logic [DATA_W-1:0] rx_word;

	// full/empty refusal lives inside the fifo
	serial_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH_P)
	) tx_fifo (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.push_i(wr_data), // [R8] [R16] [R20]
		.push_data_i(pwdata_i[DATA_W-1:0]),
		.pop_i(tx_pop), // [R9]
		.head_o(tx_head),
		.full_o(tx_full),
		.empty_o(tx_empty)
	);

	serial_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH_P)
	) rx_fifo (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.push_i(rx_push), // [R7]
		.push_data_i(rx_word),
		.pop_i(rd_data), // [R6] [R20]
		.head_o(rx_head),
		.full_o(rx_full),
		.empty_o(rx_empty)
	);

	// ---------------- link state ----------------
	link_state_t link_state_reg;
	logic [4:0] bit_cnt_reg;
	logic [DATA_W-1:0] tx_shift_reg;
	logic [DATA_W-1:0] rx_shift_reg;
	logic [2:0] sclk_sync_reg;
	logic [2:0] frame_sync_reg;
	logic [1:0] rx_sync_reg;

	fifo_status_t status;
	// busy also covers queued transmit data, so software can poll one bit before disabling
	assign status.busy = (link_state_reg == LINK_SHIFT) | ~tx_empty; // [R18]
	assign status.rx_full = rx_full; // [R19]
	assign status.rx_nonempty = ~rx_empty; // [R19]
	assign status.tx_notfull = ~tx_full; // [R19]
	assign status.tx_empty = tx_empty; // [R19]

	// ---------------- register read mux ----------------
	wire [31:0] cfg_value = {27'h0000000, cmd_format_reg, size_m1_reg};
	wire [31:0] ctl_value = {30'h00000000, enable_reg, loopback_reg};
	wire [31:0] data_value = {16'h0000, rx_head};
	wire [31:0] stat_value = {27'h0000000, status}; // [R17]
	wire [31:0] read_value = hit_cfg ? cfg_value :
		hit_ctl ? ctl_value :
		hit_data ? data_value :
		hit_stat ? stat_value : 32'h00000000;

	assign pready_o = 1'b1;
	assign prdata_o = prdata_reg;
	assign pslverr_o = pslverr_reg;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata_reg <= 32'h00000000;
		end else if (setup_phase) begin
			// captured in setup so the access edge pops exactly the word shown
			prdata_reg <= pwrite_i ? 32'h00000000 : read_value;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pslverr_reg <= 1'b0;
		end else if (setup_phase) begin
			pslverr_reg <= bad_access; // [R17]
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			size_m1_reg <= SIZE_M1_RESET;
		end else if (wr_cfg) begin
			size_m1_reg <= pwdata_i[SIZE_MSB:SIZE_LSB];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cmd_format_reg <= FORMAT_RESET;
		end else if (wr_cfg) begin
			cmd_format_reg <= pwdata_i[FORMAT_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			enable_reg <= ENABLE_RESET; // [R1]
		end else if (wr_ctl) begin
			enable_reg <= pwdata_i[ENABLE_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			loopback_reg <= LOOPBACK_RESET; // [R4]
		end else if (wr_ctl) begin
			loopback_reg <= pwdata_i[LOOPBACK_BIT]; // [R3]
		end
	end

	// ---------------- pin synchronisers ----------------
	// two stages settle each pin; the third stage of sclk and frame only finds edges
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_sync_reg <= 3'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
		end
	end

	// reset to the idle-high level so release never looks like a frame start
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			frame_sync_reg <= 3'h7;
		end else begin
			frame_sync_reg <= {frame_sync_reg[1:0], frame_n_i};
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_sync_reg <= 2'h0;
		end else begin
			rx_sync_reg <= {rx_sync_reg[0], serial_input_i};
		end
	end

	wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
	wire frame_held = ~frame_sync_reg[1];
	wire frame_start = ~frame_sync_reg[1] & frame_sync_reg[2];
	wire rx_bit = loopback_reg ? tx_shift_reg[DATA_W-1] : rx_sync_reg[1]; // [R3] [R4]

	// ---------------- frame geometry ----------------
	// sizes below four bits are not served; they are raised to four
	wire [3:0] eff_size_m1 = (size_m1_reg < MIN_SIZE_M1) ? MIN_SIZE_M1 : size_m1_reg;
	wire [4:0] word_len = {1'b0, eff_size_m1} + 5'h01;
	wire [4:0] tx_len = cmd_format_reg ? CMD_TX_BITS : word_len; // [R13]
	wire [4:0] last_bit = cmd_format_reg ? (CMD_TX_BITS + {1'b0, eff_size_m1}) :
		{1'b0, eff_size_m1}; // [R14]
	wire [4:0] tx_align = 5'h10 - tx_len;
	wire [DATA_W-1:0] tx_aligned = tx_head << tx_align; // [R11] [R13]
	wire [4:0] rx_trim = 5'h0F - {1'b0, eff_size_m1};
	wire [DATA_W-1:0] rx_mask = 16'hFFFF >> rx_trim;
	wire rx_phase = ~cmd_format_reg | (bit_cnt_reg >= CMD_TX_BITS); // [R14]
	wire shifting = link_state_reg == LINK_SHIFT;

	wire word_done = shifting & sclk_rise & (bit_cnt_reg == last_bit);
	// next word loads on the fall after the last rise: the last bit stands its whole
	// high phase, and no fall can shift away the new word's first bit
	wire word_next = shifting & sclk_fall & (bit_cnt_reg == 5'h00);
	wire load_word = enable_reg & frame_held &
		(frame_start & ~shifting | word_next); // [R1] [R9]
	assign tx_pop = load_word & ~tx_empty; // [R9]
	assign rx_word = {rx_shift_reg[DATA_W-2:0], rx_bit} & rx_mask; // [R12]
	assign rx_push = word_done & enable_reg; // [R7]

	assign serial_output_pin_o = tx_shift_reg[DATA_W-1]; // [R10]
	assign serial_output_oe_n_o = ~shifting;

	// ---------------- shifter ----------------
	// disabling only stops the shifter; fifos are untouched
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			link_state_reg <= LINK_IDLE;
			bit_cnt_reg <= 5'h00;
			tx_shift_reg <= 16'h0000;
			rx_shift_reg <= 16'h0000;
		end else begin
			case (link_state_reg)
				LINK_IDLE: begin
					bit_cnt_reg <= 5'h00;
					rx_shift_reg <= 16'h0000;
					if (load_word) begin
						link_state_reg <= LINK_SHIFT;
						// underrun sends zeros rather than stale data
						tx_shift_reg <= tx_empty ? 16'h0000 : tx_aligned; // [R9]
					end else begin
						tx_shift_reg <= 16'h0000;
					end
				end
				LINK_SHIFT: begin
					if (!enable_reg || !frame_held) begin // [R1] [R15]
						link_state_reg <= LINK_IDLE;
						tx_shift_reg <= 16'h0000;
					end else if (word_done) begin
						// a full receive queue refuses the push; that word is lost
						bit_cnt_reg <= 5'h00;
						rx_shift_reg <= 16'h0000;
					end else if (load_word) begin
						tx_shift_reg <= tx_empty ? 16'h0000 : tx_aligned; // [R9]
					end else if (sclk_rise) begin
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
						if (rx_phase)
							rx_shift_reg <= {rx_shift_reg[DATA_W-2:0], rx_bit};
					end else if (sclk_fall) begin
						tx_shift_reg <= {tx_shift_reg[DATA_W-2:0], 1'b0}; // [R10]
					end
				end
				default: begin
					link_state_reg <= LINK_IDLE;
				end
			endcase
		end
	end
endmodule

// >>> serial_port_pkg.sv
// constants, register map and carrier types for the synchronous serial port
package serial_port_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 8;

	localparam logic [ADDR_W-1:0] FRAME_CFG_OFFSET = 12'h000;
	localparam logic [ADDR_W-1:0] CONTROL_ONE_OFFSET = 12'h004;
	localparam logic [ADDR_W-1:0] DATA_WINDOW_OFFSET = 12'h008;
	localparam logic [ADDR_W-1:0] FIFO_STATUS_OFFSET = 12'h00C;

	// frame config fields
	localparam int SIZE_LSB = 0;
	localparam int SIZE_MSB = 3;
	localparam int FORMAT_BIT = 4;
	localparam logic [3:0] SIZE_M1_RESET = 4'h7;
	localparam logic [3:0] MIN_SIZE_M1 = 4'h3;
	localparam logic FORMAT_RESET = 1'b0;

	// control one fields
	localparam int LOOPBACK_BIT = 0;
	localparam int ENABLE_BIT = 1;
	localparam logic LOOPBACK_RESET = 1'b0;
	localparam logic ENABLE_RESET = 1'b0;

	// command format transmit length
	localparam logic [4:0] CMD_TX_BITS = 5'h08;

	typedef struct packed {
		logic busy;
		logic rx_full;
		logic rx_nonempty;
		logic tx_notfull;
		logic tx_empty;
	} fifo_status_t;

	typedef enum logic {
		LINK_IDLE,
		LINK_SHIFT
	} link_state_t;
endpackage

// >>> serial_fifo.sv
// synchronous fifo with push/pop refusal at full/empty
`timescale 1ns/1ps
module serial_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic push_i,
	input wire logic [WIDTH-1:0] push_data_i,
	input wire logic pop_i,
	output logic [WIDTH-1:0] head_o,
	output logic full_o,
	output logic empty_o
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = PTR_W + 1;
	localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(DEPTH);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("serial_fifo depth must be a power of two, at least 2");
		if (WIDTH < 1)
			$error("serial_fifo width must be positive");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wptr_reg;
	logic [PTR_W-1:0] rptr_reg;
	logic [CNT_W-1:0] count_reg;

	wire push_ok = push_i & ~full_o;
	wire pop_ok = pop_i & ~empty_o;

	assign full_o = count_reg == DEPTH_CNT;
	assign empty_o = count_reg == '0;
	assign head_o = mem[rptr_reg];

	always_ff @(posedge clk_i) begin
		if (push_ok)
			mem[wptr_reg] <= push_data_i;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push_ok)
				wptr_reg <= wptr_reg + 1'b1;
			if (pop_ok)
				rptr_reg <= rptr_reg + 1'b1;
			if (push_ok && !pop_ok)
				count_reg <= count_reg + 1'b1;
			else if (pop_ok && !push_ok)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule

// >>> sync_serial_port_monitor.sv
// assertion checker for register answers and pin behaviour of the serial port
`timescale 1ns/1ps
module sync_serial_port_monitor (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [serial_port_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic frame_n_i,
	input wire logic serial_output_pin_o,
	input wire logic serial_output_oe_n_o
);
	import serial_port_pkg::*;
	wire setup = psel_i && !penable_i;
	wire rd_acc = psel_i && penable_i && !pwrite_i;
	wire mapped = paddr_i < 12'h010 && paddr_i[1:0] == 2'h0;
	wire stat = paddr_i == FIFO_STATUS_OFFSET;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	a_ready_const: assert property (pready_o)
		else $error("pready low");
	a_unmapped_err: assert property (setup && !mapped |=> pslverr_o)
		else $error("unmapped access not refused");
	a_status_ro: assert property (setup && pwrite_i && stat |=> pslverr_o)
		else $error("status write not refused");
	a_window_ok: assert property (setup && paddr_i == DATA_WINDOW_OFFSET |=> !pslverr_o)
		else $error("data window refused");
	a_window_width: assert property (rd_acc && paddr_i == DATA_WINDOW_OFFSET |-> prdata_o[31:16] == 16'h0)
		else $error("data window upper bits set");
	a_status_flags: assert property (rd_acc && stat |-> prdata_o[31:5] == 27'h0 && !(prdata_o[0] && !prdata_o[1]) && !(prdata_o[3] && !prdata_o[2]))
		else $error("status flags inconsistent");
	a_busy_pending: assert property (rd_acc && stat && !prdata_o[0] |-> prdata_o[4])
		else $error("busy low with tx data waiting");
	a_busy_frame: assert property ((setup && !pwrite_i && stat && !serial_output_oe_n_o) ##1 !serial_output_oe_n_o |-> prdata_o[4])
		else $error("busy low while shifting");
	a_idle_pin: assert property (serial_output_oe_n_o |-> !serial_output_pin_o)
		else $error("pin driven while idle");
	a_frame_end: assert property (frame_n_i [*6] |=> serial_output_oe_n_o)
		else $error("shifting outside a frame");
endmodule
bind sync_serial_port sync_serial_port_monitor mon (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .frame_n_i(frame_n_i),
	.serial_output_pin_o(serial_output_pin_o), .serial_output_oe_n_o(serial_output_oe_n_o));

// >>> serial_master_model.sv
// behavioural link master: mode 0, msb first, clock still between frames
`timescale 1ns/1ps
module serial_master_model (
	output logic sclk_o,
	output logic frame_n_o,
	output logic mosi_o,
	input wire logic miso_i
);
	initial begin
		sclk_o = 1'b0;
		frame_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
		rx = 64'h0;
		#7 frame_n_o = 1'b0;
		#160;
		for (int i = n - 1; i >= 0; i--) begin
			mosi_o = tx[i];
			#80 sclk_o = 1'b1;
			// sample late in the high phase: the port changes its bit after the fall
			#79 rx = {rx[62:0], miso_i};
			#1 sclk_o = 1'b0;
		end
		#80 frame_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#200;
	endtask
endmodule

// >>> sync_serial_port_bench.sv
// self-checking bench for the synchronous serial port
`timescale 1ns/1ps
module sync_serial_port_bench;
	import serial_port_pkg::*;
	logic clk_i = 1'b0, arst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [ADDR_W-1:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0, prdata_o, rd, w;
	logic pready_o, pslverr_o, err, sclk, frame_n, mosi, miso, oe_n;
	logic [15:0] tx[8], mv;
	logic [7:0] m[8];
	logic [63:0] got, mcat = '0, ecat = '0;
	int miscompares = 0, comparisons = 0;
	initial forever #10 clk_i = ~clk_i;
	sync_serial_port dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sclk_i(sclk),
		.frame_n_i(frame_n), .serial_input_i(mosi), .serial_output_pin_o(miso),
		.serial_output_oe_n_o(oe_n));
	serial_master_model model (.sclk_o(sclk), .frame_n_o(frame_n), .mosi_o(mosi), .miso_i(miso));
	// bits the port should put on its pin for one word
	function automatic logic [31:0] pin_word(logic [15:0] v, int s, logic cmd);
		return cmd ? 32'(v[7:0]) << s : 32'(v) & ((32'h1 << s) - 32'h1);
	endfunction
	task automatic chk(logic [63:0] g, logic [63:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(logic wr_en, logic [ADDR_W-1:0] a, logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr_en;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// only the watchdog ends a wait for pready
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic rchk(logic [ADDR_W-1:0] a, logic [31:0] e);
		apb(1'b0, a, '0);
		chk(64'(rd), 64'(e));
	endtask
	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		results();
	end
	initial begin
		void'($urandom(32'hC3E7));
		repeat (5) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rchk(FIFO_STATUS_OFFSET, 32'h3);
		rchk(CONTROL_ONE_OFFSET, 32'h0);
		apb(1'b0, 12'h010, '0);
		chk(64'(err), 64'h1);
		apb(1'b1, FIFO_STATUS_OFFSET, 32'hFF);
		chk(64'(err), 64'h1);
		model.xfer(8, 64'hA5, got);
		rchk(FIFO_STATUS_OFFSET, 32'h3);
		// ninth write meets a full queue and must be dropped
		for (int i = 0; i < 9; i++) begin
			w = $urandom;
			if (i < 8)
				tx[i] = w[15:0];
			apb(1'b1, DATA_WINDOW_OFFSET, w);
		end
		rchk(FIFO_STATUS_OFFSET, 32'h10);
		apb(1'b1, CONTROL_ONE_OFFSET, 32'h2);
		for (int i = 0; i < 8; i++) begin
			m[i] = 8'($urandom);
			mcat = (mcat << 8) | 64'(m[i]);
			ecat = (ecat << 8) | 64'(pin_word(tx[i], 8, 1'b0));
		end
		fork
			model.xfer(64, mcat, got);
			begin
				#400;
				rchk(FIFO_STATUS_OFFSET, 32'h12);
			end
		join
		chk(got, ecat);
		rchk(FIFO_STATUS_OFFSET, 32'hF);
		model.xfer(8, 64'h5A, got);
		chk(got, 64'h0);
		rchk(FIFO_STATUS_OFFSET, 32'hF);
		apb(1'b1, CONTROL_ONE_OFFSET, 32'h0);
		for (int i = 0; i < 8; i++)
			rchk(DATA_WINDOW_OFFSET, 32'(m[i]));
		rchk(FIFO_STATUS_OFFSET, 32'h3);
		apb(1'b0, DATA_WINDOW_OFFSET, '0);
		rchk(FIFO_STATUS_OFFSET, 32'h3);
		w = $urandom;
		apb(1'b1, CONTROL_ONE_OFFSET, 32'h1);
		apb(1'b1, DATA_WINDOW_OFFSET, w);
		apb(1'b1, CONTROL_ONE_OFFSET, 32'h3);
		model.xfer(8, 64'(8'($urandom)), got);
		chk(got, 64'(pin_word(w[15:0], 8, 1'b0)));
		rchk(DATA_WINDOW_OFFSET, pin_word(w[15:0], 8, 1'b0));
		apb(1'b1, CONTROL_ONE_OFFSET, 32'h0);
		apb(1'b1, FRAME_CFG_OFFSET, 32'h13);
		apb(1'b1, CONTROL_ONE_OFFSET, 32'h2);
		w = $urandom;
		apb(1'b1, DATA_WINDOW_OFFSET, w);
		mv = 16'($urandom) & 16'h0FFF;
		model.xfer(12, 64'(mv), got);
		chk(got, 64'(pin_word(w[15:0], 4, 1'b1)));
		rchk(DATA_WINDOW_OFFSET, 32'(mv[3:0]));
		results();
	end
endmodule
